// file: sad_decoder.sv
// Purpose: Steers each memory or I/O request to memory, hub, graphics
//          port or system bus, or terminates it specially.
// Assumes: One request per clock; answer one clock later, registered.
// Notes: Configuration bits are plain ports held stable by software.
`default_nettype none
module sad_decoder
    import sad_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Configuration.
    input wire sad_cfg_s cfg_i,
    // Request and answer.
    input wire sad_req_s req_i,
    output var sad_rsp_s rsp_o
);
    // Inclusive range test used by every window except the top segment and the aperture.
    function automatic logic in_rng(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // Shadow attribute lookup: returns {write_en, read_en}.
    function automatic logic [1:0] shadow_attr(input logic [31:0] a,
                                               input sad_cfg_s c);
        logic [1:0] at;
        logic [3:0] seg;
        at = ATTR_RST;
        seg = a[SEG_POS +: 4];
        if (a < EXT_BIOS_LO) begin
            at = c.isa_exp_attr[{seg[2:0], 1'b0} +: 2];
        end else if (a < SYS_BIOS_LO) begin
            at = c.ext_bios_attr[{seg[1:0], 1'b0} +: 2];
        end else begin
            at = c.sys_bios_attr;
        end
        return at;
    endfunction

    // Combinational decode of the current request.
    logic [31:0] top_smm_segment_sz;
    logic [31:0] top_smm_segment_lo;
    logic [31:0] ap_mask;
    logic smm_ok;
    logic from_cpu;
    logic [1:0] attr;
    sad_rsp_s rsp_nxt;

    always_comb begin
        case (cfg_i.top_segment_size)
            2'h0: top_smm_segment_sz = TOP_SMM_SEGMENT_128K;
            2'h1: top_smm_segment_sz = TOP_SMM_SEGMENT_256K;
            2'h2: top_smm_segment_sz = TOP_SMM_SEGMENT_512K;
            default: top_smm_segment_sz = TOP_SMM_SEGMENT_1M;
        endcase
        top_smm_segment_lo = cfg_i.top_low_memory - top_smm_segment_sz;
        ap_mask = (32'h0000_0001 << (AP_SIZE_POS + 32'(cfg_i.aperture_size)))
                  - 32'h0000_0001;
        from_cpu = (req_i.src == SAD_SRC_CPU);
        // Valid SMM access: CPU only, global enable plus open or SMM code fetch.
        smm_ok = from_cpu && cfg_i.smm_global_enable &&
                 (cfg_i.smm_space_open || (req_i.smm && req_i.code));
        attr = shadow_attr(req_i.addr, cfg_i);
        rsp_nxt = '0;
        rsp_nxt.valid = req_i.valid;
        rsp_nxt.addr = req_i.addr;
        rsp_nxt.target_ready_n = 1'b1;
        rsp_nxt.dst = SAD_DST_HUB;
        if (req_i.is_io) begin
            // I/O space: 17-bit address, all ports forwarded to the hub.
            rsp_nxt.addr = {15'h0000, req_i.addr[16:0]};
            if (cfg_i.mono_adapter_present &&
                (req_i.addr[16:0] == MONO_IO_A ||
                 req_i.addr[16:0] == MONO_IO_B ||
                 req_i.addr[16:0] == MONO_IO_C ||
                 req_i.addr[16:0] == MONO_IO_D ||
                 req_i.addr[16:0] == MONO_IO_E ||
                 req_i.addr[16:0] == MONO_IO_F)) begin
                rsp_nxt.dst = SAD_DST_HUB;
            end
        end else if (in_rng(req_i.addr, HSMM_LO, HSMM_HI) &&
                     cfg_i.high_smram_enable) begin
            // SMM checks first, high window.
            if (smm_ok) begin
                rsp_nxt.dst = SAD_DST_MEM;
                rsp_nxt.addr = req_i.addr - HSMM_LO + VGA_LO;
            end else if (!from_cpu) begin
                rsp_nxt.dst = SAD_DST_SPECIAL;
                rsp_nxt.addr = ZERO_ADDR;
                rsp_nxt.addr0_data = !req_i.write;
            end else begin
                rsp_nxt.dst = SAD_DST_SPECIAL;
            end
        end else if (cfg_i.smm_global_enable && cfg_i.top_segment_enable &&
                     req_i.addr >= top_smm_segment_lo &&
                     req_i.addr < cfg_i.top_low_memory) begin
            if (smm_ok) begin
                rsp_nxt.dst = SAD_DST_MEM;
            end else begin
                rsp_nxt.dst = SAD_DST_SPECIAL;
                rsp_nxt.addr0_data = !from_cpu && !req_i.write;
                if (!from_cpu) begin
                    rsp_nxt.addr = ZERO_ADDR;
                end
            end
        end else if (in_rng(req_i.addr, VGA_LO, VGA_HI)) begin
            if (smm_ok) begin
                rsp_nxt.dst = SAD_DST_MEM;
            end else if (cfg_i.mono_adapter_present &&
                         in_rng(req_i.addr, MONO_LO, MONO_HI)) begin
                rsp_nxt.dst = SAD_DST_HUB;
            end else if (cfg_i.legacy_video_to_graphics_enable) begin
                rsp_nxt.dst = SAD_DST_GFX;
            end else begin
                rsp_nxt.dst = SAD_DST_HUB;
            end
        end else if (in_rng(req_i.addr, ISA_EXP_LO, SYS_BIOS_HI)) begin
            // Read uses bit 0 of the attribute, write uses bit 1.
            if (req_i.write ? attr[1] : attr[0]) begin
                rsp_nxt.dst = SAD_DST_MEM;
            end else begin
                rsp_nxt.dst = SAD_DST_HUB;
            end
        end else if (in_rng(req_i.addr, IOINT_LO, IOINT_HI)) begin
            rsp_nxt.dst = SAD_DST_HUB;
        end else if (in_rng(req_i.addr, INTMSG_LO, INTMSG_HI)) begin
            if (req_i.src == SAD_SRC_GFX && req_i.write) begin
                rsp_nxt.dst = SAD_DST_SYSBUS;
                rsp_nxt.target_ready_n = 1'b0;
            end else begin
                // Nothing valid answers here otherwise.
                rsp_nxt.dst = SAD_DST_DISCARD;
                rsp_nxt.zero_data = !req_i.write;
            end
        end else if (cfg_i.isa_hole_enable &&
                     in_rng(req_i.addr, ISA_HOLE_LO, ISA_HOLE_HI)) begin
            rsp_nxt.dst = SAD_DST_HUB;
        end else if ((req_i.addr & ~ap_mask) ==
                     (cfg_i.aperture_base & ~ap_mask) &&
                     req_i.addr >= cfg_i.top_low_memory) begin
            rsp_nxt.dst = SAD_DST_MEM;
        end else if (in_rng(req_i.addr, cfg_i.gfx_mem_window_base,
                            cfg_i.gfx_mem_window_limit) ||
                     in_rng(req_i.addr, cfg_i.gfx_prefetch_window_base,
                            cfg_i.gfx_prefetch_window_limit)) begin
            rsp_nxt.dst = SAD_DST_GFX;
        end else if (req_i.addr < cfg_i.top_low_memory) begin
            rsp_nxt.dst = SAD_DST_MEM;
        end else begin
            rsp_nxt.dst = SAD_DST_HUB;
        end
    end

    // Registered answer.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rsp_o <= '{valid: 1'b0, dst: SAD_DST_HUB, addr: 32'h0000_0000,
                       zero_data: 1'b0, addr0_data: 1'b0,
                       target_ready_n: 1'b1};
        end else begin
            rsp_o <= rsp_nxt;
        end
    end

    // Checks on decode results, one cycle after the request.
    property p_hub_gfx_no_smm_mem;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && req_i.src != SAD_SRC_CPU && !req_i.is_io &&
         in_rng(req_i.addr, HSMM_LO, HSMM_HI) && cfg_i.high_smram_enable)
        |=> (rsp_o.dst == SAD_DST_SPECIAL && rsp_o.addr == ZERO_ADDR);
    endproperty
    a_hub_gfx_no_smm_mem: assert property (p_hub_gfx_no_smm_mem)
        else $error("Foreign SMM access not specially terminated.");

    property p_ioint_to_hub;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && from_cpu &&
         in_rng(req_i.addr, IOINT_LO, IOINT_HI))
        |=> rsp_o.dst == SAD_DST_HUB;
    endproperty
    a_ioint_to_hub: assert property (p_ioint_to_hub)
        else $error("Interrupt controller access not sent to hub.");

    property p_intmsg;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && req_i.src == SAD_SRC_GFX &&
         req_i.write && in_rng(req_i.addr, INTMSG_LO, INTMSG_HI))
        |=> (rsp_o.dst == SAD_DST_SYSBUS && !rsp_o.target_ready_n);
    endproperty
    a_intmsg: assert property (p_intmsg)
        else $error("Interrupt write not forwarded as message.");

    property p_high_remap;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && smm_ok &&
         cfg_i.high_smram_enable && req_i.addr == HSMM_LO)
        |=> (rsp_o.dst == SAD_DST_MEM && rsp_o.addr == VGA_LO);
    endproperty
    a_high_remap: assert property (p_high_remap)
        else $error("High SMM window not remapped.");

    property p_mono_hub;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && !smm_ok &&
         cfg_i.mono_adapter_present && req_i.addr == MONO_LO)
        |=> rsp_o.dst == SAD_DST_HUB;
    endproperty
    a_mono_hub: assert property (p_mono_hub)
        else $error("Mono range not sent to hub.");

    property p_top_smm_segment_nonsmm;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && !smm_ok &&
         cfg_i.smm_global_enable && cfg_i.top_segment_enable &&
         req_i.addr == cfg_i.top_low_memory - 32'h0000_0001 &&
         req_i.addr >= top_smm_segment_lo && !in_rng(req_i.addr, HSMM_LO, HSMM_HI))
        |=> rsp_o.dst == SAD_DST_SPECIAL;
    endproperty
    a_top_smm_segment_nonsmm: assert property (p_top_smm_segment_nonsmm)
        else $error("Non-SMM top segment access reached memory.");

    property p_sysbios_reset;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && cfg_i.sys_bios_attr == ATTR_RST &&
         req_i.addr == SYS_BIOS_LO)
        |=> rsp_o.dst == SAD_DST_HUB;
    endproperty
    a_sysbios_reset: assert property (p_sysbios_reset)
        else $error("Disabled system BIOS access not sent to hub.");

    property p_invalid_read_zero;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && !req_i.write &&
         in_rng(req_i.addr, INTMSG_LO, INTMSG_HI))
        |=> (rsp_o.dst == SAD_DST_DISCARD && rsp_o.zero_data);
    endproperty
    a_invalid_read_zero: assert property (p_invalid_read_zero)
        else $error("Read of invalid space not answered with zeros.");

    property p_io_space;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && req_i.is_io)
        |=> (rsp_o.dst == SAD_DST_HUB && rsp_o.addr[31:17] == 15'h0000 &&
             rsp_o.addr[16:0] == $past(req_i.addr[16:0]));
    endproperty
    a_io_space: assert property (p_io_space)
        else $error("I/O request not forwarded with a 17-bit port.");

    property p_hole_hub;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && cfg_i.isa_hole_enable &&
         !cfg_i.top_segment_enable &&
         in_rng(req_i.addr, ISA_HOLE_LO, ISA_HOLE_HI))
        |=> rsp_o.dst == SAD_DST_HUB;
    endproperty
    a_hole_hub: assert property (p_hole_hub)
        else $error("ISA hole access not sent to hub.");

    property p_video_hub;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && !smm_ok &&
         !cfg_i.legacy_video_to_graphics_enable &&
         !cfg_i.top_segment_enable && in_rng(req_i.addr, VGA_LO, VGA_HI))
        |=> rsp_o.dst == SAD_DST_HUB;
    endproperty
    a_video_hub: assert property (p_video_hub)
        else $error("Legacy video access not sent to hub.");

    property p_video_smm_mem;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (req_i.valid && !req_i.is_io && smm_ok &&
         !cfg_i.top_segment_enable && in_rng(req_i.addr, VGA_LO, VGA_HI))
        |=> rsp_o.dst == SAD_DST_MEM;
    endproperty
    a_video_smm_mem: assert property (p_video_smm_mem)
        else $error("SMM video access not steered to memory.");

    property p_valid_follows;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        req_i.valid |=> rsp_o.valid ##1 (rsp_o.valid == $past(req_i.valid));
    endproperty
    a_valid_follows: assert property (p_valid_follows)
        else $error("Answer does not follow request by one cycle.");
endmodule
`default_nettype wire

// file: sad_pkg.sv
// Purpose: Shared constants and carriers for the system address decoder.
// Assumes: 32-bit memory addresses, 17-bit I/O addresses (64 KB plus 3).
// Notes: Every fixed range boundary and field code lives here once.
`default_nettype none
package sad_pkg;
    // Fixed memory range boundaries.
    localparam logic [31:0] VGA_LO = 32'h000A_0000;
    localparam logic [31:0] MONO_LO = 32'h000B_0000;
    localparam logic [31:0] MONO_HI = 32'h000B_7FFF;
    localparam logic [31:0] VGA_HI = 32'h000B_FFFF;
    localparam logic [31:0] ISA_EXP_LO = 32'h000C_0000;
    localparam logic [31:0] EXT_BIOS_LO = 32'h000E_0000;
    localparam logic [31:0] SYS_BIOS_LO = 32'h000F_0000;
    localparam logic [31:0] SYS_BIOS_HI = 32'h000F_FFFF;
    localparam logic [31:0] ISA_HOLE_LO = 32'h00F0_0000;
    localparam logic [31:0] ISA_HOLE_HI = 32'h00FF_FFFF;
    localparam logic [31:0] IOINT_LO = 32'hFEC0_0000;
    localparam logic [31:0] IOINT_HI = 32'hFEC7_FFFF;
    localparam logic [31:0] HSMM_LO = 32'hFEDA_0000;
    localparam logic [31:0] HSMM_HI = 32'hFEDB_FFFF;
    localparam logic [31:0] INTMSG_LO = 32'hFEE0_0000;
    localparam logic [31:0] INTMSG_HI = 32'hFEEF_FFFF;
    localparam logic [31:0] ZERO_ADDR = 32'h0000_0000;
    // Shadow segment index field: 16 KB segments start at bit 14.
    localparam int SEG_POS = 14;
    // Top segment sizes in bytes, selected by the 2-bit size field.
    localparam logic [31:0] TOP_SMM_SEGMENT_128K = 32'h0002_0000;
    localparam logic [31:0] TOP_SMM_SEGMENT_256K = 32'h0004_0000;
    localparam logic [31:0] TOP_SMM_SEGMENT_512K = 32'h0008_0000;
    localparam logic [31:0] TOP_SMM_SEGMENT_1M = 32'h0010_0000;
    // Aperture size field: mask of low address bits (0 means 4 MB).
    localparam int AP_SIZE_POS = 22;
    // Mono display I/O ports.
    localparam logic [16:0] MONO_IO_A = 17'h003B4;
    localparam logic [16:0] MONO_IO_B = 17'h003B5;
    localparam logic [16:0] MONO_IO_C = 17'h003B8;
    localparam logic [16:0] MONO_IO_D = 17'h003B9;
    localparam logic [16:0] MONO_IO_E = 17'h003BA;
    localparam logic [16:0] MONO_IO_F = 17'h003BF;
    // Shadow attribute codes: bit 0 read enable, bit 1 write enable.
    localparam logic [1:0] ATTR_RST = 2'h0;
    // Requester codes.
    typedef enum logic [1:0] {
        SAD_SRC_CPU = 2'h0,
        SAD_SRC_HUB = 2'h1,
        SAD_SRC_GFX = 2'h2
    } sad_src_e;
    // Destination codes of a decoded request.
    typedef enum logic [2:0] {
        SAD_DST_MEM = 3'h0,
        SAD_DST_HUB = 3'h1,
        SAD_DST_GFX = 3'h2,
        SAD_DST_SYSBUS = 3'h3,
        SAD_DST_SPECIAL = 3'h4,
        SAD_DST_DISCARD = 3'h5
    } sad_dst_e;
    // One incoming request.
    typedef struct packed {
        logic valid;
        sad_src_e src;
        logic is_io;
        logic write;
        logic smm;
        logic code;
        logic [31:0] addr;
    } sad_req_s;
    // One decoded answer.
    typedef struct packed {
        logic valid;
        sad_dst_e dst;
        logic [31:0] addr;
        logic zero_data;
        logic addr0_data;
        logic target_ready_n;
    } sad_rsp_s;
    // Configuration carrier.
    typedef struct packed {
        logic [31:0] top_low_memory;
        logic legacy_video_to_graphics_enable;
        logic mono_adapter_present;
        logic smm_global_enable;
        logic smm_space_open;
        logic isa_hole_enable;
        logic [1:0] top_segment_size;
        logic top_segment_enable;
        logic high_smram_enable;
        logic [31:0] aperture_base;
        logic [2:0] aperture_size;
        logic [31:0] gfx_mem_window_base;
        logic [31:0] gfx_mem_window_limit;
        logic [31:0] gfx_prefetch_window_base;
        logic [31:0] gfx_prefetch_window_limit;
        logic [15:0] isa_exp_attr;
        logic [7:0] ext_bios_attr;
        logic [1:0] sys_bios_attr;
    } sad_cfg_s;
endpackage
`default_nettype wire

// file: sad_req_model.sv
// Purpose: Requester model on the far side of the address decoder.
// Assumes: Requests change on the falling edge and stand for one cycle.
// Notes: A released address shows its inverse, never the old value.
`default_nettype none
module sad_req_model
    import sad_pkg::*;
(
    // Clock.
    input wire logic ref_clk_i,
    // Request toward the decoder.
    output var sad_req_s req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // The request starts idle at time zero.
    initial begin
        req_o = '0;
    end

    // Presents one request for one cycle, then releases it.
    task automatic send(input sad_req_s r);
        @(negedge ref_clk_i);
        req_o = r;
        @(negedge ref_clk_i);
        req_o.valid = 1'b0;
        req_o.addr = ~r.addr;
    endtask
endmodule
`default_nettype wire

// file: test_system_address_decoder.sv
// Purpose: Self-checking bench for the system address decoder.
// Assumes: One request at a time, answer seen within three cycles.
// Notes: Configuration is changed only between requests.
`default_nettype none
module test_system_address_decoder;
    import sad_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] RD = 4'h0;
    localparam logic [3:0] WR = 4'h4;
    localparam logic [3:0] SMC = 4'h3;
    localparam logic [3:0] SMD = 4'h2;
    localparam logic [3:0] IO = 4'h8;
    localparam sad_src_e CPU = SAD_SRC_CPU;
    localparam sad_src_e HUB = SAD_SRC_HUB;
    localparam sad_src_e GFX = SAD_SRC_GFX;
    localparam logic [31:0] TOP = 32'h1000_0000;
    logic ref_clk_i;
    logic sys_rst_i;
    sad_cfg_s cfg;
    sad_req_s req;
    sad_rsp_s rsp;
    sad_rsp_s got;
    int bad_count;
    int total_checks;
    logic [16:0] ports [6];
    logic [31:0] sizes [4];

    sad_req_model u_req (.ref_clk_i(ref_clk_i), .req_o(req));
    sad_decoder u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .cfg_i(cfg), .req_i(req), .rsp_o(rsp));

    // Free-running 50 MHz clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] want,
                         input string what);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Sends one request and captures its answer under a bounded wait.
    task automatic go(input sad_src_e s, input logic [3:0] f,
                      input logic [31:0] a, input sad_dst_e d);
        sad_req_s r;
        int n;
        r = '{valid: 1'b1, src: s, is_io: f[3], write: f[2], smm: f[1],
              code: f[0], addr: a};
        u_req.send(r);
        n = 0;
        while (rsp.valid !== 1'b1 && n < 3) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (rsp.valid !== 1'b1) begin
            bad_count++;
            $display("BAD t=%0t no answer for %h", $time, a);
            wrap_up();
        end
        got = rsp;
        check(32'(got.dst), 32'(d), "destination");
    endtask

    // Main sequence: reset, then one group of requests per behaviour.
    initial begin
        bad_count = 0;
        total_checks = 0;
        ports = '{MONO_IO_A, MONO_IO_B, MONO_IO_C, MONO_IO_D, MONO_IO_E,
                  MONO_IO_F};
        sizes = '{TOP_SMM_SEGMENT_128K, TOP_SMM_SEGMENT_256K, TOP_SMM_SEGMENT_512K, TOP_SMM_SEGMENT_1M};
        sys_rst_i = 1'b1;
        cfg = '0;
        cfg.top_low_memory = TOP;
        cfg.aperture_base = 32'hE000_0000;
        cfg.gfx_mem_window_base = 32'hD000_0000;
        cfg.gfx_mem_window_limit = 32'hD0FF_FFFF;
        cfg.gfx_prefetch_window_base = 32'hD100_0000;
        cfg.gfx_prefetch_window_limit = 32'hD1FF_FFFF;
        cfg.sys_bios_attr = ATTR_RST;
        repeat (5) @(negedge ref_clk_i);
        check(32'(rsp.valid), 32'h0, "reset valid");
        check(32'(rsp.target_ready_n), 32'h1, "reset ready");
        sys_rst_i = 1'b0;
        go(CPU, RD, SYS_BIOS_LO, SAD_DST_HUB);
        go(CPU, WR, SYS_BIOS_HI, SAD_DST_HUB);
        cfg.sys_bios_attr = 2'h3;
        go(CPU, RD, SYS_BIOS_LO, SAD_DST_MEM);
        go(CPU, RD, ZERO_ADDR, SAD_DST_MEM);
        go(CPU, WR, TOP - 32'h1, SAD_DST_MEM);
        go(CPU, RD, TOP, SAD_DST_HUB);
        go(CPU, WR, 32'h3000_0000, SAD_DST_HUB);
        $display("test memory done");
        go(CPU, RD, VGA_LO, SAD_DST_HUB);
        cfg.legacy_video_to_graphics_enable = 1'b1;
        go(CPU, RD, VGA_HI, SAD_DST_GFX);
        go(CPU, WR, MONO_LO, SAD_DST_GFX);
        cfg.mono_adapter_present = 1'b1;
        go(CPU, WR, MONO_LO, SAD_DST_HUB);
        go(CPU, RD, MONO_HI, SAD_DST_HUB);
        go(CPU, RD, MONO_HI + 32'h1, SAD_DST_GFX);
        cfg.smm_global_enable = 1'b1;
        go(CPU, SMD, VGA_LO, SAD_DST_GFX);
        go(CPU, SMC, VGA_LO, SAD_DST_MEM);
        cfg.smm_space_open = 1'b1;
        go(CPU, RD, MONO_LO, SAD_DST_MEM);
        cfg.smm_space_open = 1'b0;
        cfg.smm_global_enable = 1'b0;
        for (int k = 0; k < 6; k++) begin
            go(CPU, IO, {15'h0, ports[k]}, SAD_DST_HUB);
        end
        go(CPU, IO, 32'h0001_0002, SAD_DST_HUB);
        check(got.addr, 32'h0001_0002, "port address");
        cfg.legacy_video_to_graphics_enable = 1'b0;
        cfg.mono_adapter_present = 1'b0;
        $display("test video done");
        // Each ISA segment i gets attribute i modulo 4, the others none.
        for (int i = 0; i < 8; i++) begin
            cfg.isa_exp_attr = 16'h0000;
            cfg.isa_exp_attr[2*i +: 2] = 2'(i);
            go(CPU, RD, ISA_EXP_LO + 32'(i) * 32'h4000,
               i[0] ? SAD_DST_MEM : SAD_DST_HUB);
            go(CPU, WR, ISA_EXP_LO + 32'(i) * 32'h4000 + 32'h3FFF,
               i[1] ? SAD_DST_MEM : SAD_DST_HUB);
        end
        for (int i = 0; i < 4; i++) begin
            cfg.ext_bios_attr = 8'h00;
            cfg.ext_bios_attr[2*i +: 2] = 2'(3 - i);
            go(CPU, RD, EXT_BIOS_LO + 32'(i) * 32'h4000,
               (i == 0 || i == 2) ? SAD_DST_MEM : SAD_DST_HUB);
            go(CPU, WR, EXT_BIOS_LO + 32'(i) * 32'h4000 + 32'h3FFF,
               (i < 2) ? SAD_DST_MEM : SAD_DST_HUB);
        end
        $display("test shadow done");
        go(CPU, RD, ISA_HOLE_LO, SAD_DST_MEM);
        cfg.isa_hole_enable = 1'b1;
        go(CPU, RD, ISA_HOLE_LO, SAD_DST_HUB);
        go(CPU, WR, ISA_HOLE_HI, SAD_DST_HUB);
        go(CPU, RD, ISA_HOLE_HI + 32'h1, SAD_DST_MEM);
        cfg.isa_hole_enable = 1'b0;
        $display("test hole done");
        cfg.smm_global_enable = 1'b1;
        cfg.top_segment_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            cfg.top_segment_size = 2'(k);
            go(CPU, RD, TOP - sizes[k], SAD_DST_SPECIAL);
            go(CPU, RD, TOP - sizes[k] - 32'h1, SAD_DST_MEM);
            go(CPU, SMC, TOP - 32'h1, SAD_DST_MEM);
            go(HUB, RD, TOP - sizes[k], SAD_DST_SPECIAL);
            check(32'(got.addr0_data), 32'h1, "address zero data");
            check(got.addr, ZERO_ADDR, "foreign address");
            go(CPU, WR, TOP - 32'h1, SAD_DST_SPECIAL);
        end
        cfg.top_segment_enable = 1'b0;
        go(CPU, RD, TOP - 32'h1, SAD_DST_MEM);
        $display("test top segment done");
        cfg.high_smram_enable = 1'b1;
        go(CPU, SMC, HSMM_LO, SAD_DST_MEM);
        check(got.addr, VGA_LO, "remap low");
        go(CPU, SMC, HSMM_HI, SAD_DST_MEM);
        check(got.addr, VGA_HI, "remap high");
        go(CPU, RD, HSMM_LO, SAD_DST_SPECIAL);
        go(GFX, RD, HSMM_LO, SAD_DST_SPECIAL);
        check(got.addr, ZERO_ADDR, "foreign high address");
        check(32'(got.addr0_data), 32'h1, "address zero data");
        cfg.high_smram_enable = 1'b0;
        cfg.smm_global_enable = 1'b0;
        $display("test high window done");
        go(CPU, RD, IOINT_LO, SAD_DST_HUB);
        go(CPU, WR, IOINT_HI, SAD_DST_HUB);
        go(GFX, WR, INTMSG_LO, SAD_DST_SYSBUS);
        check(32'(got.target_ready_n), 32'h0, "target ready");
        go(CPU, RD, INTMSG_HI, SAD_DST_DISCARD);
        check(32'(got.zero_data), 32'h1, "zero data");
        go(CPU, WR, INTMSG_LO, SAD_DST_DISCARD);
        go(CPU, RD, 32'hE000_0000, SAD_DST_MEM);
        go(CPU, WR, 32'hE03F_FFFF, SAD_DST_MEM);
        go(CPU, RD, 32'hE040_0000, SAD_DST_HUB);
        go(CPU, RD, 32'hD000_0000, SAD_DST_GFX);
        go(CPU, WR, 32'hD0FF_FFFF, SAD_DST_GFX);
        go(CPU, RD, 32'hD1FF_FFFF, SAD_DST_GFX);
        go(CPU, RD, 32'hD200_0000, SAD_DST_HUB);
        $display("test high ranges done");
        wrap_up();
    end
endmodule
`default_nettype wire
